/* core/dsrpc_dcinj.v */
`include "dsrpc_defs.vh"

module dsrpc_dcinj (
    input wire clk_i, // system clock
    input wire nrst_i, // async reset, active low
    input wire tenth_i, // 0.1 s tick enable
    input wire run_i, // run commanded
    input wire zero_i, // speed is zero
    input wire [1:0] mode_i, // injection mode
    input wire [8:0] dur_i, // injection time, 0.1 s
    input wire three_wire_i, // pulse control selected
    input wire li1_i, // logic input one, synchronised
    output reg inject_o // dc injection active
);

    reg [8:0] cnt_r;
    wire cond;

    // under pulse control input one gates injection
    assign cond = !run_i && zero_i && (!three_wire_i || li1_i);

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_r <= 9'h000;
            inject_o <= 1'b0;
        end
        else if (!cond || mode_i == `DSRPC_INJ_OFF)
        begin
            cnt_r <= 9'h000;
            inject_o <= 1'b0;
        end
        else if (mode_i == `DSRPC_INJ_CONT)
            inject_o <= 1'b1;
        else if (mode_i == `DSRPC_INJ_TIMED)
        begin
            // counter stays at the limit so injection ends until cond drops
            inject_o <= (cnt_r < dur_i);
            if (tenth_i && cnt_r < dur_i)
                cnt_r <= cnt_r + 9'h001;
        end
        else
            inject_o <= 1'b0;
    end

endmodule // dsrpc_dcinj

/* core/dsrpc_defs.vh */
`ifndef DSRPC_DEFS_VH
`define DSRPC_DEFS_VH

// parameter identifiers on the write port
`define DSRPC_P_RAMP2_SEL 4'h0
`define DSRPC_P_ACCEL2 4'h1
`define DSRPC_P_DECEL2 4'h2
`define DSRPC_P_LINE_LOSS 4'h3
`define DSRPC_P_ADAPT 4'h4
`define DSRPC_P_INJ_MODE 4'h5
`define DSRPC_P_INJ_DUR 4'h6
`define DSRPC_P_INJ_CUR 4'h7
`define DSRPC_P_PWM_RANGE 4'h8
`define DSRPC_P_PWM_FREQ 4'h9

// ramp times in 0.1 s
`define DSRPC_RAMP_MIN 10'h001
`define DSRPC_RAMP_MAX 10'h3E7
`define DSRPC_RAMP_DEF 10'h032

// line-loss stop modes
`define DSRPC_LL_FREEWHEEL 2'h0
`define DSRPC_LL_RAMP 2'h1
`define DSRPC_LL_FAST 2'h2

// injection modes and limits
`define DSRPC_INJ_OFF 2'h0
`define DSRPC_INJ_TIMED 2'h1
`define DSRPC_INJ_CONT 2'h2
`define DSRPC_INJ_DUR_MIN 9'h001
`define DSRPC_INJ_DUR_MAX 9'h12C
`define DSRPC_INJ_DUR_DEF 9'h005
`define DSRPC_INJ_CUR_MAX 4'hC
`define DSRPC_INJ_CUR_DEF 4'h7

// switching ranges and frequency codes
`define DSRPC_PWM_LOW_RANDOM 2'h0
`define DSRPC_PWM_LOW_FIXED 2'h1
`define DSRPC_PWM_HIGH_FIXED 2'h2
`define DSRPC_FC_2K 5'h02
`define DSRPC_FC_4K 5'h04
`define DSRPC_FC_8K 5'h08
`define DSRPC_FC_12K 5'h0C
`define DSRPC_FC_16K 5'h0F
`define DSRPC_KHZ_16 5'h10

// timing
`define DSRPC_CLK_HZ 250000000
`define DSRPC_BASE_TICK_US 100
`define DSRPC_BASE_TICK_CYC ((`DSRPC_CLK_HZ / 1000000) * `DSRPC_BASE_TICK_US)
`define DSRPC_TICKS_PER_TENTH 1000

// frequencies in 0.1 Hz
`define DSRPC_FNOM 16'h01F4
`define DSRPC_HIGH_SPEED 16'h01C2

`endif

/* core/dsrpc_ramp.v */
`include "dsrpc_defs.vh"

module dsrpc_ramp #(
    parameter [15:0] FNOM = `DSRPC_FNOM,
    parameter [23:0] TPT = `DSRPC_TICKS_PER_TENTH
) (
    input wire clk_i, // system clock
    input wire nrst_i, // async reset, active low
    input wire tick_i, // base tick enable
    input wire clear_i, // force frequency to zero
    input wire [15:0] target_i, // reference frequency
    input wire [9:0] acc_time_i, // active accel time
    input wire [9:0] dec_time_i, // active decel time
    input wire fast_i, // brake as hard as possible
    input wire adapt_i, // deceleration adaptation enable
    input wire overvolt_i, // bus overvoltage, synchronised
    output reg [15:0] freq_o, // output frequency
    output reg at_zero_o // frequency is zero
);

    reg [23:0] acc_r;
    wire [9:0] dtime;
    wire [23:0] sum;
    wire [23:0] lim_up;
    wire [23:0] lim_dn;
    wire hold;

    function [23:0] ramp_lim;
        input [9:0] t;
        begin
            ramp_lim = {14'h0000, t} * TPT;
        end
    endfunction

    assign dtime = fast_i ? `DSRPC_RAMP_MIN : dec_time_i;
    assign sum = acc_r + {8'h00, FNOM};
    assign lim_up = ramp_lim(acc_time_i);
    assign lim_dn = ramp_lim(dtime);
    // holding the slope while the bus is high stretches the ramp
    assign hold = adapt_i & overvolt_i;

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            acc_r <= 24'h000000;
            freq_o <= 16'h0000;
            at_zero_o <= 1'b1;
        end
        else
        begin
            at_zero_o <= (freq_o == 16'h0000);
            if (clear_i)
            begin
                acc_r <= 24'h000000;
                freq_o <= 16'h0000;
            end
            else if (tick_i)
            begin
                if (freq_o < target_i)
                begin
                    if (sum >= lim_up)
                    begin
                        acc_r <= sum - lim_up;
                        freq_o <= freq_o + 16'h0001;
                    end
                    else
                        acc_r <= sum;
                end
                else if (freq_o > target_i)
                begin
                    if (!hold)
                    begin
                        if (sum >= lim_dn)
                        begin
                            acc_r <= sum - lim_dn;
                            freq_o <= freq_o - 16'h0001;
                        end
                        else
                            acc_r <= sum;
                    end
                end
                else
                    acc_r <= 24'h000000;
            end
        end
    end

endmodule // dsrpc_ramp

/* core/dsrpc_top.v */
`include "dsrpc_defs.vh"

// Summary of operation
// - parameter writes only when stopped and locked
// - second ramp selector: off or inputs 1-4
// - second ramp times need an assigned selector
// - second accel 0.1 to 99.9 s, default 5.0
// - second decel 0.1 to 99.9 s, default 5.0
// - line loss default: lock, freewheel stop
// - line loss ramp: decelerate on valid ramp
// - line loss fast: brake as hard as possible
// - timed injection after stop for set time
// - continuous injection while stopped, no limit
// - pulse control: inject only when input one high
// - injection time/current visible by mode
// - injection time 0.1 to 30.0 s, default 0.5
// - injection current 0 to 1.2 In, default 0.7
// - switching range: random low, fixed low, high
// - frequency codes limited by range, defaults 4/12
// - 2 kHz becomes 4 kHz at high speed
// - high range steps down when drive too hot
module dsrpc_top #(
    parameter BASE_TICK_CYC = `DSRPC_BASE_TICK_CYC,
    parameter TICKS_PER_TENTH = `DSRPC_TICKS_PER_TENTH,
    parameter [15:0] FNOM = `DSRPC_FNOM,
    parameter [15:0] HIGH_SPEED = `DSRPC_HIGH_SPEED
) (
    input wire clk_i, // 250 MHz system clock
    input wire nrst_i, // async reset, active low
    input wire wr_i, // parameter write strobe
    input wire [3:0] wr_addr_i, // parameter identifier
    input wire [15:0] wr_data_i, // parameter value
    input wire [3:0] logic_in_i, // logic input pins 1-4
    input wire run_cmd_i, // run command pin
    input wire line_ok_i, // line supply present pin
    input wire overvolt_i, // bus overvoltage pin
    input wire thermal_hot_i, // drive thermal state too high pin
    input wire three_wire_i, // pulse control selected
    input wire [15:0] ref_freq_i, // speed reference, 0.1 Hz
    input wire [9:0] accel1_time_i, // primary accel time, 0.1 s
    input wire [9:0] decel_time_primary_i, // primary decel time, 0.1 s
    output reg wr_ok_o, // write accepted pulse
    output reg wr_err_o, // write refused pulse
    output wire [15:0] freq_o, // output frequency, 0.1 Hz
    output reg drive_en_o, // power stage modulation enable
    output reg drive_locked_o, // drive stopped and locked
    output wire inject_o, // dc injection active
    output reg [3:0] inject_current_o, // injection current, 0.1 In
    output reg [4:0] pwm_khz_o, // switching frequency, kHz
    output reg pwm_random_o, // random dithering enabled
    output reg ramp2_active_o // second ramp pair in use
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RUN = 2'h1;
    localparam [1:0] ST_LOSS_STOP = 2'h2;
    localparam [1:0] ST_LOCKED = 2'h3;

    reg [7:0] sync1_r;
    reg [7:0] sync2_r;
    reg [31:0] base_cnt_r;
    reg base_tick_r;
    reg [31:0] tenth_cnt_r;
    reg tenth_tick_r;
    reg [2:0] ramp2_input_sel_r;
    reg [9:0] accel2_time_r;
    reg [9:0] decel2_time_r;
    reg [1:0] loss_mode_r;
    reg adapt_r;
    reg [1:0] function_mode_sel_r;
    reg [8:0] inject_duration_r;
    reg [3:0] inject_current_r;
    reg [1:0] pwm_range_sel_r;
    reg [4:0] pwm_freq_code_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg wr_accept;
    reg [4:0] pwm_eff;

    wire [3:0] li_s;
    wire run_s;
    wire line_ok_s;
    wire overvolt_s;
    wire hot_s;
    wire ramp2_on;
    wire [9:0] acc_time;
    wire [9:0] dec_time;
    wire [15:0] target;
    wire at_zero;
    wire stopped_locked;
    wire fast_stop;
    wire clear_freq;
    wire [2:0] sel_w;

    function range_ok;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            range_ok = (v >= lo) && (v <= hi);
        end
    endfunction

    function code_ok;
        input [1:0] rng;
        input [4:0] code;
        begin
            if (rng == `DSRPC_PWM_HIGH_FIXED)
                code_ok = (code == `DSRPC_FC_8K) || (code == `DSRPC_FC_12K) ||
                          (code == `DSRPC_FC_16K);
            else
                code_ok = (code == `DSRPC_FC_2K) || (code == `DSRPC_FC_4K);
        end
    endfunction

    // run, line, overvolt, thermal and logic input pins cross in one two-stage bank; three_wire_i does not
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
        end
        else
        begin
            sync1_r <= {thermal_hot_i, overvolt_i, line_ok_i, run_cmd_i, logic_in_i};
            sync2_r <= sync1_r;
        end
    end

    assign li_s = sync2_r[3:0];
    assign run_s = sync2_r[4];
    assign line_ok_s = sync2_r[5];
    assign overvolt_s = sync2_r[6];
    assign hot_s = sync2_r[7];

    // base tick drives the ramp, tenth tick the injection timer
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            base_cnt_r <= 32'h00000000;
            base_tick_r <= 1'b0;
            tenth_cnt_r <= 32'h00000000;
            tenth_tick_r <= 1'b0;
        end
        else
        begin
            base_tick_r <= (base_cnt_r == BASE_TICK_CYC - 1);
            if (base_cnt_r == BASE_TICK_CYC - 1)
                base_cnt_r <= 32'h00000000;
            else
                base_cnt_r <= base_cnt_r + 32'h00000001;
            tenth_tick_r <= 1'b0;
            if (base_tick_r)
            begin
                if (tenth_cnt_r == TICKS_PER_TENTH - 1)
                begin
                    tenth_cnt_r <= 32'h00000000;
                    tenth_tick_r <= 1'b1;
                end
                else
                    tenth_cnt_r <= tenth_cnt_r + 32'h00000001;
            end
        end
    end

    assign sel_w = ramp2_input_sel_r - 3'h1;
    assign ramp2_on = (ramp2_input_sel_r != 3'h0) && li_s[sel_w[1:0]];
    assign acc_time = ramp2_on ? accel2_time_r : accel1_time_i;
    // the valid decel ramp also governs a ramp stop on line loss
    assign dec_time = ramp2_on ? decel2_time_r : decel_time_primary_i;
    assign fast_stop = (state_r == ST_LOSS_STOP) && (loss_mode_r == `DSRPC_LL_FAST);
    assign target = (state_r == ST_RUN) ? ref_freq_i : 16'h0000;
    assign clear_freq = (state_r == ST_LOCKED) || (state_r == ST_IDLE && !drive_en_o);
    assign stopped_locked = (state_r == ST_IDLE || state_r == ST_LOCKED) &&
                            !drive_en_o && at_zero;

    // run state machine
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (run_s && line_ok_s)
                    state_nxt = ST_RUN;
            ST_RUN:
                if (!line_ok_s)
                begin
                    if (loss_mode_r == `DSRPC_LL_FREEWHEEL)
                        state_nxt = ST_LOCKED;
                    else
                        state_nxt = ST_LOSS_STOP;
                end
                else if (!run_s)
                    state_nxt = ST_IDLE;
            ST_LOSS_STOP:
                if (at_zero)
                    state_nxt = ST_LOCKED;
            ST_LOCKED:
                // restart needs the run command withdrawn and the line back
                if (!run_s && line_ok_s)
                    state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_r <= ST_IDLE;
            drive_en_o <= 1'b0;
            drive_locked_o <= 1'b1;
            inject_current_o <= 4'h0;
            ramp2_active_o <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_nxt == ST_LOCKED)
                drive_en_o <= 1'b0;
            else if (state_nxt == ST_RUN || state_nxt == ST_LOSS_STOP)
                drive_en_o <= 1'b1;
            else if (at_zero)
                drive_en_o <= 1'b0;
            // a start leaving idle this cycle must not show as locked next cycle
            drive_locked_o <= stopped_locked && (state_nxt != ST_RUN);
            inject_current_o <= inject_o ? inject_current_r : 4'h0;
            ramp2_active_o <= ramp2_on;
        end
    end

    // write acceptance and access gating
    always @*
    begin
        wr_accept = 1'b0;
        if (!stopped_locked || !drive_locked_o)
            wr_accept = 1'b0;
        else if (wr_addr_i == `DSRPC_P_RAMP2_SEL)
            wr_accept = (wr_data_i <= 16'h0004);
        else if (wr_addr_i == `DSRPC_P_ACCEL2 || wr_addr_i == `DSRPC_P_DECEL2)
            wr_accept = (ramp2_input_sel_r != 3'h0) &&
                        range_ok(wr_data_i, {6'h00, `DSRPC_RAMP_MIN},
                                 {6'h00, `DSRPC_RAMP_MAX});
        else if (wr_addr_i == `DSRPC_P_LINE_LOSS)
            wr_accept = (wr_data_i <= {14'h0000, `DSRPC_LL_FAST});
        else if (wr_addr_i == `DSRPC_P_ADAPT)
            wr_accept = (wr_data_i <= 16'h0001);
        else if (wr_addr_i == `DSRPC_P_INJ_MODE)
            wr_accept = (wr_data_i <= {14'h0000, `DSRPC_INJ_CONT});
        else if (wr_addr_i == `DSRPC_P_INJ_DUR)
            wr_accept = (function_mode_sel_r == `DSRPC_INJ_TIMED) &&
                        range_ok(wr_data_i, {7'h00, `DSRPC_INJ_DUR_MIN},
                                 {7'h00, `DSRPC_INJ_DUR_MAX});
        else if (wr_addr_i == `DSRPC_P_INJ_CUR)
            wr_accept = (function_mode_sel_r != `DSRPC_INJ_OFF) &&
                        (wr_data_i <= {12'h000, `DSRPC_INJ_CUR_MAX});
        else if (wr_addr_i == `DSRPC_P_PWM_RANGE)
            wr_accept = (wr_data_i <= {14'h0000, `DSRPC_PWM_HIGH_FIXED});
        else if (wr_addr_i == `DSRPC_P_PWM_FREQ)
            wr_accept = (wr_data_i[15:5] == 11'h000) &&
                        code_ok(pwm_range_sel_r, wr_data_i[4:0]);
        else
            wr_accept = 1'b0;
    end

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wr_ok_o <= 1'b0;
            wr_err_o <= 1'b0;
            ramp2_input_sel_r <= 3'h0;
            accel2_time_r <= `DSRPC_RAMP_DEF;
            decel2_time_r <= `DSRPC_RAMP_DEF;
            loss_mode_r <= `DSRPC_LL_FREEWHEEL;
            adapt_r <= 1'b1;
            function_mode_sel_r <= `DSRPC_INJ_TIMED;
            inject_duration_r <= `DSRPC_INJ_DUR_DEF;
            inject_current_r <= `DSRPC_INJ_CUR_DEF;
            pwm_range_sel_r <= `DSRPC_PWM_LOW_FIXED;
            pwm_freq_code_r <= `DSRPC_FC_4K;
        end
        else
        begin
            wr_ok_o <= wr_i && wr_accept;
            wr_err_o <= wr_i && !wr_accept;
            if (wr_i && wr_accept)
            begin
                case (wr_addr_i)
                    `DSRPC_P_RAMP2_SEL: ramp2_input_sel_r <= wr_data_i[2:0];
                    `DSRPC_P_ACCEL2: accel2_time_r <= wr_data_i[9:0];
                    `DSRPC_P_DECEL2: decel2_time_r <= wr_data_i[9:0];
                    `DSRPC_P_LINE_LOSS: loss_mode_r <= wr_data_i[1:0];
                    `DSRPC_P_ADAPT: adapt_r <= wr_data_i[0];
                    `DSRPC_P_INJ_MODE: function_mode_sel_r <= wr_data_i[1:0];
                    `DSRPC_P_INJ_DUR: inject_duration_r <= wr_data_i[8:0];
                    `DSRPC_P_INJ_CUR: inject_current_r <= wr_data_i[3:0];
                    `DSRPC_P_PWM_RANGE:
                    begin
                        pwm_range_sel_r <= wr_data_i[1:0];
                        // a code invalid for the new range falls back to its default
                        if (!code_ok(wr_data_i[1:0], pwm_freq_code_r))
                            pwm_freq_code_r <= (wr_data_i[1:0] == `DSRPC_PWM_HIGH_FIXED) ?
                                               `DSRPC_FC_12K : `DSRPC_FC_4K;
                    end
                    `DSRPC_P_PWM_FREQ: pwm_freq_code_r <= wr_data_i[4:0];
                    default: ;
                endcase
            end
        end
    end

    // effective switching frequency
    always @*
    begin
        if (pwm_freq_code_r == `DSRPC_FC_16K)
            pwm_eff = `DSRPC_KHZ_16;
        else
            pwm_eff = pwm_freq_code_r;
        if (pwm_range_sel_r == `DSRPC_PWM_HIGH_FIXED)
        begin
            if (hot_s)
            begin
                if (pwm_freq_code_r == `DSRPC_FC_16K)
                    pwm_eff = `DSRPC_FC_12K;
                else if (pwm_freq_code_r == `DSRPC_FC_12K)
                    pwm_eff = `DSRPC_FC_8K;
                else
                    pwm_eff = `DSRPC_FC_4K;
            end
        end
        else if (pwm_freq_code_r == `DSRPC_FC_2K && freq_o >= HIGH_SPEED)
            pwm_eff = `DSRPC_FC_4K;
    end

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pwm_khz_o <= `DSRPC_FC_4K;
            pwm_random_o <= 1'b0;
        end
        else
        begin
            pwm_khz_o <= pwm_eff;
            pwm_random_o <= (pwm_range_sel_r == `DSRPC_PWM_LOW_RANDOM);
        end
    end

    dsrpc_ramp #(
        .FNOM(FNOM),
        .TPT(TICKS_PER_TENTH[23:0])
    ) u_ramp (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .tick_i(base_tick_r),
        .clear_i(clear_freq),
        .target_i(target),
        .acc_time_i(acc_time),
        .dec_time_i(dec_time),
        .fast_i(fast_stop),
        .adapt_i(adapt_r),
        .overvolt_i(overvolt_s),
        .freq_o(freq_o),
        .at_zero_o(at_zero)
    );

    // input one doubles as the stop input under pulse control
    dsrpc_dcinj u_dcinj (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .tenth_i(tenth_tick_r),
        // a held run command blocks injection after a loss stop too
        .run_i(run_s || state_r == ST_RUN),
        .zero_i(at_zero),
        .mode_i(function_mode_sel_r),
        .dur_i(inject_duration_r),
        .three_wire_i(three_wire_i),
        .li1_i(li_s[0]),
        .inject_o(inject_o)
    );

endmodule // dsrpc_top

/* test/dsrpc_checker.sv */
module dsrpc_checker (
    input wire clk_i, // clock
    input wire nrst_i, // reset
    input wire wr_i, // write strobe
    input wire [3:0] wr_addr_i, // id
    input wire [15:0] wr_data_i, // value
    input wire wr_ok_o, // accepted
    input wire wr_err_o, // refused
    input wire [15:0] freq_o, // frequency
    input wire drive_en_o, // modulating
    input wire drive_locked_o, // locked
    input wire inject_o, // injecting
    input wire [3:0] inject_current_o, // current
    input wire [4:0] pwm_khz_o, // kHz
    input wire pwm_random_o, // dither
    input wire ramp2_active_o // ramp two
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_busy_write_refused: assert property (wr_i && !drive_locked_o |=> wr_err_o && !wr_ok_o)
        else $error("write taken while running");
    a_bad_id_refused: assert property (wr_i && wr_addr_i > 4'h9 |=> wr_err_o)
        else $error("unknown id taken");
    a_no_stray_answer: assert property (!wr_i |=> !wr_ok_o && !wr_err_o)
        else $error("answer without write");
    a_accel2_zero: assert property (wr_i && wr_addr_i == 4'h1 && wr_data_i == 16'h0 |=> wr_err_o)
        else $error("zero accel time taken");
    a_locked_output_off: assert property (drive_locked_o |-> !drive_en_o && freq_o == 16'h0)
        else $error("output live while locked");
    a_inject_standstill: assert property (inject_o |-> freq_o == 16'h0)
        else $error("injection while turning");
    a_current_idle_zero: assert property (!inject_o |=> inject_current_o == 4'h0)
        else $error("current without injection");
    a_khz_legal: assert property (pwm_khz_o inside {5'h02, 5'h04, 5'h08, 5'h0C, 5'h10})
        else $error("illegal switching rate");
    a_random_low_only: assert property (pwm_random_o |-> pwm_khz_o <= 5'h04)
        else $error("dither outside low range");
    c_wr_ok: cover property (wr_ok_o);
    c_inject: cover property (inject_o);
    c_ramp2: cover property (ramp2_active_o);
    c_random: cover property (pwm_random_o);
endmodule // dsrpc_checker

bind dsrpc_top dsrpc_checker u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .wr_i(wr_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .wr_ok_o(wr_ok_o), .wr_err_o(wr_err_o),
    .freq_o(freq_o), .drive_en_o(drive_en_o), .drive_locked_o(drive_locked_o),
    .inject_o(inject_o), .inject_current_o(inject_current_o), .pwm_khz_o(pwm_khz_o),
    .pwm_random_o(pwm_random_o), .ramp2_active_o(ramp2_active_o));

/* test/dsrpc_stage_model.sv */
module dsrpc_stage_model (
    input wire clk_i, // clock
    input wire drive_en_i, // modulating
    input wire [15:0] freq_i, // frequency
    input wire heat_i, // heavy load
    input wire regen_i, // load feeds back
    output logic overvolt_o = 1'b0, // bus too high
    output logic thermal_hot_o = 1'b0 // stage too hot
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] prev_r = 16'h0;
    always @(posedge clk_i)
    begin
        prev_r <= freq_i;
        // bus only rises while a feeding load is slowed
        overvolt_o <= regen_i && drive_en_i && freq_i < prev_r;
        thermal_hot_o <= heat_i && drive_en_i;
    end
endmodule // dsrpc_stage_model

/* test/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, nrst_i = 0, wr_i = 0, run = 0, line = 1, tw = 0, heat = 0, regen = 0;
    logic [3:0] addr = 4'h0, li = 4'h0;
    logic [15:0] data = 16'h0;
    logic [15:0] rf = 16'h001E;
    logic [9:0] a1 = 10'h001, d1 = 10'h001;
    wire ok, err, en, lck, inj, rnd, r2, ov, hot;
    wire [15:0] f;
    wire [3:0] cur;
    wire [4:0] khz;
    int failures = 0;
    int tests_run = 0;
    always #2 clk_i = ~clk_i;
    dsrpc_top #(.BASE_TICK_CYC(4), .TICKS_PER_TENTH(4), .HIGH_SPEED(16'h0014)) u_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .wr_i(wr_i), .wr_addr_i(addr), .wr_data_i(data),
        .logic_in_i(li), .run_cmd_i(run), .line_ok_i(line), .overvolt_i(ov),
        .thermal_hot_i(hot), .three_wire_i(tw), .ref_freq_i(rf),
        .accel1_time_i(a1), .decel_time_primary_i(d1), .wr_ok_o(ok),
        .wr_err_o(err), .freq_o(f), .drive_en_o(en), .drive_locked_o(lck), .inject_o(inj),
        .inject_current_o(cur), .pwm_khz_o(khz), .pwm_random_o(rnd), .ramp2_active_o(r2));
    dsrpc_stage_model u_stage (.clk_i(clk_i), .drive_en_i(en), .freq_i(f), .heat_i(heat),
        .regen_i(regen), .overvolt_o(ov), .thermal_hot_o(hot));
    task report_and_stop;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(string n, logic [15:0] s, logic [15:0] e);
        tests_run++;
        if (s !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(logic [3:0] a, logic [15:0] d, logic e);
        @(negedge clk_i);
        addr = a;
        data = d;
        wr_i = 1;
        @(negedge clk_i);
        wr_i = 0;
        chk("wr_answer", {ok, err}, {e, !e});
    endtask
    task wt(int s, logic [15:0] v);
        for (int i = 0; i < 3000; i++)
        begin
            @(negedge clk_i);
            if ((s == 0 ? f : s == 1 ? {15'h0, inj} : {15'h0, lck}) === v)
                return;
        end
        failures++;
        $display("Error wait %0d expected %h seen timeout", s, v);
        report_and_stop;
    endtask
    task t_params;
        wr(4'h1, 16'h0032, 0);
        wr(4'h0, 16'h0005, 0);
        wr(4'h0, 16'h0001, 1);
        wr(4'h1, 16'h0000, 0);
        wr(4'h1, 16'h03E7, 1);
        wr(4'h2, 16'h03E8, 0);
        wr(4'h6, 16'h012D, 0);
        wr(4'h6, 16'h0002, 1);
        wr(4'h7, 16'h000D, 0);
        wr(4'h7, 16'h000C, 1);
        wr(4'h9, 16'h0008, 0);
        wr(4'h9, 16'h0002, 1);
        wr(4'h8, 16'h0000, 1);
        repeat (3) @(negedge clk_i);
        chk("pwm_random_o", rnd, 1);
        wr(4'h8, 16'h0001, 1);
        repeat (3) @(negedge clk_i);
        chk("pwm_khz_o", khz, 2);
        wr(4'hA, 16'h0000, 0);
        wr(4'h4, 16'h0001, 1);
    endtask
    task t_run;
        run = 1;
        wt(0, 16'h001E);
        chk("drive_en_o", en, 1);
        chk("pwm_khz_o", khz, 4);
        wr(4'h0, 16'h0002, 0);
        li = 4'h1;
        repeat (5) @(negedge clk_i);
        chk("ramp2_active_o", r2, 1);
        li = 4'h0;
    endtask
    task t_stop;
        int n;
        run = 0;
        wt(1, 1);
        @(negedge clk_i);
        chk("inject_current_o", cur, 12);
        for (n = 0; inj === 1'b1 && n < 99; n++)
            @(negedge clk_i);
        // tenth tick phase is free, so allow one tenth of slack
        chk("inject_len", n >= 14 && n <= 36, 1);
        wt(2, 1);
    endtask
    task t_cont;
        wr(4'h5, 16'h0002, 1);
        wr(4'h6, 16'h0003, 0);
        wt(1, 1);
        repeat (200) @(negedge clk_i);
        chk("inject_o", inj, 1);
        tw = 1;
        repeat (6) @(negedge clk_i);
        chk("inject_o", inj, 0);
        li = 4'h1;
        repeat (6) @(negedge clk_i);
        chk("inject_o", inj, 1);
        tw = 0;
        li = 4'h0;
        wr(4'h5, 16'h0000, 1);
        wr(4'h7, 16'h0005, 0);
        wr(4'h5, 16'h0001, 1);
    endtask
    task t_loss(logic [1:0] m);
        wr(4'h3, {14'h0, m}, 1);
        regen = m == 2;
        run = 1;
        wt(0, 16'h001E);
        line = 0;
        repeat (6) @(negedge clk_i);
        chk("drive_en_o", en, m != 0);
        if (m == 0)
            chk("freq_o", f, 0);
        wt(0, 16'h0000);
        wt(2, 1);
        run = 0;
        line = 1;
        regen = 0;
        wt(1, 1);
        wt(1, 0);
    endtask
    task t_pwm;
        wr(4'h8, 16'h0002, 1);
        repeat (3) @(negedge clk_i);
        chk("pwm_khz_o", khz, 12);
        wr(4'h9, 16'h000F, 1);
        run = 1;
        wt(0, 16'h001E);
        chk("pwm_khz_o", khz, 16);
        heat = 1;
        repeat (8) @(negedge clk_i);
        chk("pwm_khz_o", khz, 12);
        heat = 0;
        repeat (8) @(negedge clk_i);
        chk("pwm_khz_o", khz, 16);
    endtask
    initial
    begin
        repeat (3) @(negedge clk_i);
        nrst_i = 1;
        t_params;
        t_run;
        t_stop;
        t_cont;
        t_loss(0);
        t_loss(1);
        t_loss(2);
        t_pwm;
        report_and_stop;
    end
endmodule // tb
